/* apicfe_bench.sv */
// Self-checking bench for the interrupt and clock front end.
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module apicfe_bench;
    import apicfe_pkg::*;
    logic clk_sys = 0, rst_n = 0, apic_bus_clock = 0, id_reg_write = 0, sw_pci_reset = 0;
    logic pci_66_sel = 0, fb_break = 0, jam = 0;
    logic [IRQ_N-1:0] irq_n_in = '1;
    logic [PCLK_N-1:0] pci_clk_disable = '0;
    logic [APIC_W-1:0] bus_out, bus_oe, p_oe, level;
    logic boot_o, boot_oe, fb_out, pll_aligned, sec_rst_n;
    logic [PCLK_N-1:0] pclk;
    logic [IRQ_N-1:0] irq_pending;
    logic [5:0] rx_idx;
    int rx_count, n_errors = 0, tests_run = 0;
    // Pull-ups on both lines: low only where someone pulls
    assign level = ~((bus_oe & ~bus_out) | p_oe);
    initial forever #4 clk_sys = ~clk_sys;
    initial begin
        #3.3;
        forever #7.5 apic_bus_clock = ~apic_bus_clock;
    end
    apicfe_top i_apicfe_top (.clk_sys(clk_sys), .rst_n(rst_n), .apic_bus_clock(apic_bus_clock),
        .irq_n_in(irq_n_in), .id_reg_write(id_reg_write), .sw_pci_reset(sw_pci_reset),
        .pci_clk_disable(pci_clk_disable), .pci_66_sel(pci_66_sel),
        .pll_feedback_clock_in(fb_out ^ fb_break), .apic_bus_data_in(level),
        .apic_bus_data_out(bus_out), .apic_bus_data_oe(bus_oe), .boot_interrupt_out_o(boot_o),
        .boot_interrupt_out_oe(boot_oe), .pci_clock_outputs(pclk),
        .pll_feedback_clock_out(fb_out), .pll_aligned(pll_aligned),
        .secondary_bus_reset_out_n(sec_rst_n), .irq_pending(irq_pending));
    apicfe_partner i_apicfe_partner (.apic_bus_clock(apic_bus_clock), .rst_n(rst_n), .jam(jam),
        .bus_level(level), .bus_oe(p_oe), .rx_idx(rx_idx), .rx_count(rx_count));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Bounded wait for the partner to collect a given number of frames
    task automatic wait_rx(input int n);
        for (int i = 0; i < 300 && rx_count < n; i++) cyc(1);
        `CHK(rx_count >= n, 1'b1)
    endtask
    task automatic irq_drive(input int idx, input logic v);
        @(posedge clk_sys);
        irq_n_in[idx] <= v;
    endtask
    // One frame per request, pending cleared once delivered
    task automatic t_single();
        int n0 = rx_count;
        irq_drive(5, 1'b0);
        cyc(6);
        `CHK(irq_pending[5], 1'b1)
        `CHK(boot_oe, 1'b1)
        `CHK(boot_o, 1'b0)
        wait_rx(n0 + 1);
        `CHK(rx_idx, 6'h05)
        `CHK(bus_out, 2'h0)
        cyc(8);
        `CHK(irq_pending[5], 1'b0)
        irq_drive(5, 1'b1);
        cyc(5);
        `CHK(boot_oe, 1'b0)
    endtask
    // Both ends of the request range at once; lowest goes first
    task automatic t_order();
        int n0 = rx_count;
        @(posedge clk_sys);
        irq_n_in <= 24'h7ffffe;
        wait_rx(n0 + 1);
        `CHK(rx_idx, 6'h00)
        wait_rx(n0 + 2);
        `CHK(rx_idx, 6'h17)
        irq_drive(0, 1'b1);
        irq_drive(23, 1'b1);
    endtask
    // Lines held low by the far side: nothing delivered until released
    task automatic t_jam();
        int n0 = rx_count;
        @(posedge clk_sys);
        jam <= 1'b1;
        irq_drive(7, 1'b0);
        cyc(40);
        `CHK(irq_pending[7], 1'b1)
        `CHK(rx_count, n0)
        // Release only after an aborted frame, so no frame is cut in half by the release
        wait (bus_oe != 2'h0);
        wait (bus_oe == 2'h0);
        @(posedge apic_bus_clock);
        jam <= 1'b0;
        wait_rx(n0 + 1);
        `CHK(rx_idx, 6'h07)
        irq_drive(7, 1'b1);
        cyc(8);
    endtask
    // Gate pattern, rate and feedback toggles over eight cycles
    task automatic measure(input logic [5:0] dis, input logic sel, input int tog);
        logic [5:0] hi = '0;
        logic prev;
        int n = 0;
        @(posedge clk_sys);
        pci_clk_disable <= dis;
        pci_66_sel <= sel;
        cyc(6);
        prev = fb_out;
        for (int i = 0; i < 8; i++) begin
            cyc(1);
            hi |= pclk;
            n += (fb_out != prev);
            prev = fb_out;
        end
        `CHK(hi, ~dis)
        `CHK(n, tog)
    endtask
    task automatic t_clocks();
        measure(6'h00, 1'b0, 4);
        measure(6'h2a, 1'b1, 8);
        measure(6'h15, 1'b0, 4);
        measure(6'h00, 1'b1, 8);
        `CHK(pll_aligned, 1'b1)
        @(posedge clk_sys);
        fb_break <= 1'b1;
        cyc(8);
        `CHK(pll_aligned, 1'b0)
        @(posedge clk_sys);
        fb_break <= 1'b0;
    endtask
    task automatic t_swreset();
        @(posedge clk_sys);
        sw_pci_reset <= 1'b1;
        cyc(1);
        `CHK(sec_rst_n, 1'b0)
        @(posedge clk_sys);
        sw_pci_reset <= 1'b0;
        cyc(1);
        `CHK(sec_rst_n, 1'b1)
    endtask
    // Identity write silences the boot output for good; requests still go pending for the link
    task automatic t_boot_off();
        irq_drive(9, 1'b0);
        cyc(6);
        `CHK(boot_oe, 1'b1)
        @(posedge clk_sys);
        id_reg_write <= 1'b1;
        @(posedge clk_sys);
        id_reg_write <= 1'b0;
        #1;
        `CHK(boot_oe, 1'b0)
        irq_drive(9, 1'b1);
        cyc(30);
        irq_drive(9, 1'b0);
        cyc(5);
        `CHK(boot_oe, 1'b0)
        `CHK(irq_pending[9], 1'b1)
    endtask
    // Reset between clock edges clears at once, then boot output returns
    task automatic t_async();
        @(negedge clk_sys);
        rst_n = 1'b0;
        #1;
        `CHK(sec_rst_n, 1'b0)
        `CHK(irq_pending, 24'h0)
        `CHK(pclk, 6'h00)
        irq_n_in <= '1;
        cyc(8);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(4);
        irq_drive(3, 1'b0);
        cyc(6);
        `CHK(boot_oe, 1'b1)
        irq_drive(3, 1'b1);
        cyc(30);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        finish_test();
    end
    initial begin
        cyc(7);
        `CHK(sec_rst_n, 1'b0)
        `CHK({bus_oe, boot_oe, pclk}, 9'h000)
        @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(4);
        `CHK(sec_rst_n, 1'b1)
        t_single();
        t_order();
        t_jam();
        t_clocks();
        t_swreset();
        t_boot_off();
        t_async();
        finish_test();
    end
endmodule // apicfe_bench

/* apicfe_partner.sv */
// Processor-side model of the link: frame receiver and commanded line jammer.
`timescale 1ns/1ps
module apicfe_partner (
    input wire logic apic_bus_clock,
    input wire logic rst_n,
    input wire logic jam,
    input wire logic [1:0] bus_level,
    output logic [1:0] bus_oe,
    output logic [5:0] rx_idx,
    output int rx_count
);
    logic busy;
    logic [1:0] beat;
    logic [5:0] shift;
    // All activity from the link clock rise; lines are read at that edge
    always @(posedge apic_bus_clock) begin
        bus_oe <= {2{jam}}; // Pulls only while commanded, so a fault is always deliberate
        if (!rst_n) begin
            busy <= 1'b0;
            beat <= 2'h0;
            rx_idx <= 6'h00;
            rx_count <= 0;
        end else if (jam) begin
            busy <= 1'b0;
            beat <= 2'h0;
        end else if (!busy) begin
            // Our own pull is still seen one edge after release, so that low pair is no start
            busy <= (bus_level == 2'h0) && (bus_oe == 2'h0);
            beat <= 2'h0;
        end else if (beat == 2'h2) begin
            rx_idx <= {shift[3:0], bus_level};
            rx_count <= rx_count + 1;
            busy <= 1'b0;
        end else begin
            shift <= {shift[3:0], bus_level};
            beat <= beat + 2'h1;
        end
    end
endmodule // apicfe_partner

/* apicfe_pkg.sv */
// Shared constants and types for the interrupt and clock front end, plus its link-side engine.
// Functional notes
// R1 - Twenty-four request inputs, APIC style only
// R2 - Boot interrupt output signals requests after reset
// R3 - Identity register write disables boot output forever
// R4 - Sample bus data on link clock rise
// R5 - Launch new bus data from link clock rise
// R6 - Link logic runs on link clock, up to 33 MHz; the bench clocks it at about 67 MHz
// R7 - Hub logic runs on its own clock
// R8 - Six gateable PCI clocks, enabled out of reset
// R9 - Feedback clock out returns to align logic
// R10 - Reset input clears logic asynchronously
// R11 - Secondary reset on reset input or software bit
// R12 - Open-drain outputs only pull low, never high
`timescale 1ns/1ps
package apicfe_pkg;
    localparam int IRQ_N = 24;
    localparam int IDX_W = 5;
    localparam int APIC_W = 2;
    localparam int PCLK_N = 6;
    localparam logic [5:0] PCLK_EN_RST = 6'h3f;
    localparam logic [1:0] PCLK_HALF_66 = 2'h1;
    localparam logic [1:0] PCLK_HALF_33 = 2'h2;
    localparam logic [1:0] LINK_START = 2'h0;
    localparam logic [1:0] LINK_IDLE_PAIR = 2'h3;
    localparam logic [2:0] FRAME_LAST = 3'h3;
    localparam int SHIFT_W = 6;
    // Request handed from hub domain to link domain, index held while toggle is in flight
    typedef struct packed {
        logic tgl;
        logic [IDX_W-1:0] idx;
    } apicfe_req_t;
    // Completion handed back; ok changes on the same link edge as tgl and is read two hub cycles later
    typedef struct packed {
        logic tgl;
        logic ok;
    } apicfe_ack_t;
    typedef enum logic [0:0] {LINK_IDLE, LINK_SEND} apicfe_link_st_t;
endpackage

module apicfe_link (
    input wire logic clk_link,
    input wire logic rst_n,
    input wire apicfe_pkg::apicfe_req_t req_in,
    input wire logic [1:0] bus_data_in,
    output logic [1:0] bus_data_out,
    output logic [1:0] bus_data_oe,
    output apicfe_pkg::apicfe_ack_t ack_out
);
    import apicfe_pkg::*;
    logic rs1_reg, rs2_reg, link_rst_n;
    logic rq1_reg, rq2_reg;
    apicfe_link_st_t st_reg, st_next;
    logic [2:0] beat_reg, beat_next;
    logic [SHIFT_W-1:0] shift_reg, shift_next;
    logic [1:0] pair_reg, pair_next;
    logic seen_reg, seen_next;
    apicfe_ack_t ack_next;
    logic lost;

    // Reset asserts at once, releases on the link clock; the link clock may be stopped
    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            rs1_reg <= 1'b0; // R10
            rs2_reg <= 1'b0;
        end else begin
            rs1_reg <= 1'b1;
            rs2_reg <= rs1_reg;
        end
    end
    assign link_rst_n = rs2_reg;

    // Request toggle synchroniser; the index is stable long before the toggle lands
    always_ff @(posedge clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rq1_reg <= 1'b0;
            rq2_reg <= 1'b0;
        end else begin
            rq1_reg <= req_in.tgl;
            rq2_reg <= rq1_reg;
        end
    end

    // Wired-AND loss: we released a line but the sampled level is low
    assign lost = (st_reg == LINK_SEND) && (|(pair_reg & ~bus_data_in)); // R4

    // Frame engine: start pair, then the index two bits per beat
    always_comb begin
        st_next = st_reg;
        beat_next = beat_reg;
        shift_next = shift_reg;
        pair_next = pair_reg;
        seen_next = seen_reg;
        ack_next = ack_out;
        case (st_reg)
            LINK_IDLE: begin
                if (rq2_reg != seen_reg) begin
                    seen_next = rq2_reg;
                    pair_next = LINK_START; // R5
                    shift_next = {1'b0, req_in.idx};
                    beat_next = 3'h0;
                    st_next = LINK_SEND;
                end
            end
            LINK_SEND: begin
                if (lost || beat_reg == FRAME_LAST) begin
                    ack_next.tgl = ~ack_out.tgl;
                    ack_next.ok = ~lost; // R4
                    pair_next = LINK_IDLE_PAIR;
                    st_next = LINK_IDLE;
                end else begin
                    pair_next = shift_reg[SHIFT_W-1 -: 2]; // R5
                    shift_next = {shift_reg[SHIFT_W-3:0], 2'h0};
                    beat_next = beat_reg + 3'h1;
                end
            end
            default: st_next = LINK_IDLE;
        endcase
    end

    // Outside reset, everything here changes only on the rising link edge
    always_ff @(posedge clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            st_reg <= LINK_IDLE;
            beat_reg <= 3'h0;
            shift_reg <= '0;
            pair_reg <= LINK_IDLE_PAIR;
            seen_reg <= 1'b0;
            ack_out <= '0;
            bus_data_oe <= 2'h0;
            bus_data_out <= 2'h0;
        end else begin
            st_reg <= st_next; // R6
            beat_reg <= beat_next;
            shift_reg <= shift_next;
            pair_reg <= pair_next;
            seen_reg <= seen_next;
            ack_out <= ack_next;
            bus_data_oe <= ~pair_next; // R12
            bus_data_out <= 2'h0; // R12
        end
    end

    a_link_loss: assert property (@(posedge clk_link) disable iff (!link_rst_n) // R4
        lost |=> (st_reg == LINK_IDLE) && !ack_out.ok && bus_data_oe == 2'h0)
        else $error("lost arbitration did not end the frame");
    a_link_frame: assert property (@(posedge clk_link) disable iff (!link_rst_n) // R5
        $rose(st_reg == LINK_SEND) |-> bus_data_oe == 2'h3 ##[1:4] st_reg == LINK_IDLE)
        else $error("frame did not start low or ran too long");
    a_link_od: assert property (@(posedge clk_link) disable iff (!link_rst_n) // R12
        bus_data_out == 2'h0 && !(st_reg == LINK_IDLE && |bus_data_oe))
        else $error("link line driven high or held while idle");
    c_link_ok: cover property (@(posedge clk_link) disable iff (!link_rst_n)
        $rose(ack_out.tgl) && ack_out.ok);
    c_link_lost: cover property (@(posedge clk_link) disable iff (!link_rst_n) lost);
endmodule // apicfe_link

/* apicfe_top.sv */
// Interrupt and clock front end: request intake, boot interrupt, PCI clocks and resets.
`timescale 1ns/1ps
module apicfe_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic apic_bus_clock,
    input wire logic [apicfe_pkg::IRQ_N-1:0] irq_n_in,
    input wire logic id_reg_write,
    input wire logic sw_pci_reset,
    input wire logic [apicfe_pkg::PCLK_N-1:0] pci_clk_disable,
    input wire logic pci_66_sel,
    input wire logic pll_feedback_clock_in,
    input wire logic [apicfe_pkg::APIC_W-1:0] apic_bus_data_in,
    output logic [apicfe_pkg::APIC_W-1:0] apic_bus_data_out,
    output logic [apicfe_pkg::APIC_W-1:0] apic_bus_data_oe,
    output logic boot_interrupt_out_o,
    output logic boot_interrupt_out_oe,
    output logic [apicfe_pkg::PCLK_N-1:0] pci_clock_outputs,
    output logic pll_feedback_clock_out,
    output logic pll_aligned,
    output logic secondary_bus_reset_out_n,
    output logic [apicfe_pkg::IRQ_N-1:0] irq_pending
);
    import apicfe_pkg::*;

    // Pin synchronisers; the third request stage feeds edge detection only
    logic [IRQ_N-1:0] irq_s1_reg, irq_s2_reg, irq_s3_reg;
    logic sel_s1_reg, sel_s2_reg;
    logic fb_s1_reg, fb_s2_reg;
    logic ack_s1_reg, ack_s2_reg;

    // Request bookkeeping
    logic [IRQ_N-1:0] act, rise;
    logic [IRQ_N-1:0] pend_next;
    logic ack_seen_reg, ack_seen_next;
    logic busy_reg, busy_next;
    logic ack_edge;
    apicfe_req_t req_reg, req_next;
    apicfe_ack_t ack_link;
    logic any_pend;
    logic [IDX_W-1:0] pick;

    // Boot interrupt and secondary reset
    logic boot_dis_reg, boot_dis_next;
    logic boot_oe_next;
    logic sbr_n_next;

    // PCI clocks and feedback
    logic [1:0] cnt_reg, cnt_next, half;
    logic phase_reg, phase_next;
    logic [PCLK_N-1:0] en_reg, en_next, pclk_next;
    logic [1:0] fbo_hist_reg, fbo_hist_next;
    logic aligned_next;

    // Two flops on requests, rate select, feedback and link ack before anything looks at them; other inputs are used directly
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_s1_reg <= '1;
            irq_s2_reg <= '1;
            irq_s3_reg <= '1;
            sel_s1_reg <= 1'b0;
            sel_s2_reg <= 1'b0;
            fb_s1_reg <= 1'b0;
            fb_s2_reg <= 1'b0;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            irq_s1_reg <= irq_n_in;
            irq_s2_reg <= irq_s1_reg;
            irq_s3_reg <= irq_s2_reg;
            sel_s1_reg <= pci_66_sel;
            sel_s2_reg <= sel_s1_reg;
            fb_s1_reg <= pll_feedback_clock_in;
            fb_s2_reg <= fb_s1_reg;
            ack_s1_reg <= ack_link.tgl;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    // Inputs idle high behind pull-ups; a low level is a request
    assign act = ~irq_s2_reg; // R1
    assign rise = ~irq_s2_reg & irq_s3_reg;
    assign ack_edge = ack_s2_reg != ack_seen_reg;

    // Lowest pending index wins; no legacy vectoring path exists
    always_comb begin
        pick = '0;
        any_pend = 1'b0;
        for (int i = IRQ_N - 1; i >= 0; i--) begin
            if (irq_pending[i]) begin
                pick = IDX_W'(i); // R1
                any_pend = 1'b1;
            end
        end
    end

    // Pending set, handoff to the link and completion
    always_comb begin
        pend_next = irq_pending;
        busy_next = busy_reg;
        req_next = req_reg;
        ack_seen_next = ack_seen_reg;
        if (ack_edge) begin
            ack_seen_next = ack_s2_reg;
            busy_next = 1'b0;
            // A lost frame leaves the bit set so it is retried
            if (ack_link.ok) begin
                pend_next[req_reg.idx] = 1'b0;
            end
        end else if (!busy_reg && any_pend) begin
            req_next.idx = pick;
            req_next.tgl = ~req_reg.tgl;
            busy_next = 1'b1;
        end
        // A new edge in the clearing cycle must survive
        pend_next = pend_next | rise; // R1
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_pending <= '0; // R10
            busy_reg <= 1'b0;
            req_reg <= '0;
            ack_seen_reg <= 1'b0;
        end else begin
            irq_pending <= pend_next;
            busy_reg <= busy_next;
            req_reg <= req_next;
            ack_seen_reg <= ack_seen_next;
        end
    end

    // Boot path is live until the identity write, then dead until next reset
    always_comb begin
        boot_dis_next = boot_dis_reg | id_reg_write; // R3
        boot_oe_next = ~boot_dis_next & (|act); // R2
        sbr_n_next = ~sw_pci_reset; // R11
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            boot_dis_reg <= 1'b0;
            boot_interrupt_out_oe <= 1'b0;
            boot_interrupt_out_o <= 1'b0;
            secondary_bus_reset_out_n <= 1'b0; // R11
        end else begin
            boot_dis_reg <= boot_dis_next;
            boot_interrupt_out_oe <= boot_oe_next;
            boot_interrupt_out_o <= 1'b0; // R12
            secondary_bus_reset_out_n <= sbr_n_next;
        end
    end

    // Clock divider; rate select is sampled, and a change already alters the half period under way
    always_comb begin
        half = sel_s2_reg ? PCLK_HALF_66 : PCLK_HALF_33; // R8
        cnt_next = cnt_reg + 2'h1;
        phase_next = phase_reg;
        if (cnt_reg >= half - 2'h1) begin
            cnt_next = 2'h0;
            phase_next = ~phase_reg;
        end
        en_next = ~pci_clk_disable; // R8
        fbo_hist_next = {fbo_hist_reg[0], phase_reg};
        // Returned clock should track what was launched two cycles ago
        aligned_next = fb_s2_reg == fbo_hist_reg[1]; // R9
    end

    // Gated outputs park low; the raw disable input gates them, so a change mid-phase can leave a runt pulse high
    genvar g;
    generate
        for (g = 0; g < PCLK_N; g++) begin : g_pclk
            assign pclk_next[g] = en_next[g] & phase_next; // R8
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 2'h0;
            phase_reg <= 1'b0;
            en_reg <= PCLK_EN_RST; // R8
            fbo_hist_reg <= 2'h0;
            pci_clock_outputs <= '0;
            pll_feedback_clock_out <= 1'b0;
            pll_aligned <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            phase_reg <= phase_next;
            en_reg <= en_next;
            fbo_hist_reg <= fbo_hist_next;
            pci_clock_outputs <= pclk_next;
            pll_feedback_clock_out <= phase_next; // R9
            pll_aligned <= aligned_next;
        end
    end

    // Link-side engine on the bus clock; hub logic stays on clk_sys
    apicfe_link i_apicfe_link (
        .clk_link(apic_bus_clock),
        .rst_n(rst_n),
        .req_in(req_reg),
        .bus_data_in(apic_bus_data_in),
        .bus_data_out(apic_bus_data_out),
        .bus_data_oe(apic_bus_data_oe),
        .ack_out(ack_link)
    ); // R6 R7

    a_boot_forward: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
        (|act && !boot_dis_reg && !id_reg_write) |=> boot_interrupt_out_oe)
        else $error("request not forwarded on boot interrupt");
    a_boot_disable: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
        id_reg_write |=> !boot_interrupt_out_oe [*8])
        else $error("boot interrupt active after identity write");
    a_boot_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
        boot_dis_reg |=> boot_dis_reg)
        else $error("boot disable did not hold");
    a_od_boot_low: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
        !boot_interrupt_out_o)
        else $error("boot interrupt driven high");
    a_sec_reset: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
        sw_pci_reset |=> !secondary_bus_reset_out_n)
        else $error("secondary reset not asserted for software bit");
    a_pclk_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
        1'b1 |=> (pci_clock_outputs & $past(pci_clk_disable)) == '0)
        else $error("disabled pci clock toggled");
    a_irq_pend: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
        (|rise) |=> (irq_pending & $past(rise)) == $past(rise))
        else $error("request edge not recorded as pending");
    a_fb_follow: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
        (|pci_clock_outputs) |-> pll_feedback_clock_out)
        else $error("pci clock high while feedback clock low");
    c_boot_then_off: cover property (@(posedge clk_sys) disable iff (!rst_n)
        boot_interrupt_out_oe ##[1:20] id_reg_write);
    c_frame_done: cover property (@(posedge clk_sys) disable iff (!rst_n)
        ack_edge && ack_link.ok);
    c_pclk_off: cover property (@(posedge clk_sys) disable iff (!rst_n)
        en_reg != PCLK_EN_RST);
endmodule // apicfe_top
